/* testbench/tb.sv */
`timescale 1ns/1ns
// ==========================================================================
// Bench top: register bus driver, packets through the host model.
module tb;
  logic mclk, rst_n, cyc_i, stb_i, we_i, ack_o, stored, active, iso_mode, irq, send;
  logic [7:0] adr_i;
  logic [3:0] sel_i;
  logic [31:0] dat_i, dat_o, q;
  logic [5:0] pkt;
  usb_oep_pkg::rx_event_t rx;
  usb_oep_pkg::handshake_out_t handshake;
  usb_oep_pkg::buf_sel_t buf_sel;
  int bad_count = 0;
  int tests_run = 0;

  usb_oep_cfg usb_oep_cfg_i (.mclk(mclk), .rst_n(rst_n), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .rx(rx), .handshake(handshake), .buf_sel(buf_sel), .stored(stored), .active(active),
    .iso_mode(iso_mode), .irq(irq));
  usb_host_model usb_host_model_i (.mclk(mclk), .rst_n(rst_n), .send(send), .pkt(pkt),
    .rx(rx));

  // Clock at 50 ns period.
  initial begin
    mclk = 1'h0;
    forever #25 mclk = ~mclk;
  end

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic end_sim;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  // One classic cycle; the wait for the acknowledge is bounded.
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    input logic [3:0] s);
    int n;
    n = 0;
    @(posedge mclk);
    cyc_i <= 1'h1;
    stb_i <= 1'h1;
    we_i <= w;
    adr_i <= a;
    dat_i <= d;
    sel_i <= s;
    do begin
      @(posedge mclk);
      n++;
    end while (ack_o !== 1'h1 && n < 16);
    if (n >= 16) chk("ack wait", 32'h1, 32'h0);
    q = dat_o;
    cyc_i <= 1'h0;
    stb_i <= 1'h0;
  endtask : wb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'h1, a, d, 4'hF);
  endtask : wr

  task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
    wb(1'h0, a, 32'h0, 4'hF);
    chk(n, e, q);
  endtask : rd

  // One packet; the answer is judged in the cycle it stands as {valid, code, stored}.
  task automatic pk(input logic [5:0] p, input logic [3:0] e);
    @(posedge mclk);
    send <= 1'h1;
    pkt <= p;
    @(posedge mclk);
    send <= 1'h0;
    @(posedge mclk);
    @(negedge mclk);
    chk("answer", {28'h0, e}, {28'h0, handshake, stored});
  endtask : pk

  task automatic t_reset;
    for (int a = 0; a < 6; a++) begin
      rd("reset value", 8'(a * 4), 32'h0);
    end
    rd("unmapped", 8'h18, 32'h0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_geom;
    wr(8'h00, 32'h18);
    wr(8'h04, 32'h21);
    wr(8'h0C, 32'h40);
    wb(1'h1, 8'h00, 32'hFF, 4'h0);
    rd("size lane", 8'h00, 32'h18);
    rd("pri base", 8'h04, 32'h21);
    wr(8'h08, 32'h90);
    chk("sel pri", {9'h0, 11'h108, 11'h0C0, 1'h0}, {9'h0, buf_sel});
    pk(6'h10, 4'hB);
    chk("sel sec", {9'h0, 11'h200, 11'h0C0, 1'h1}, {9'h0, buf_sel});
    pk(6'h18, 4'hB);
    chk("sel back", {9'h0, 11'h108, 11'h0C0, 1'h0}, {9'h0, buf_sel});
    wr(8'h08, 32'h80);
    pk(6'h10, 4'hB);
    chk("single", {9'h0, 11'h108, 11'h0C0, 1'h0}, {9'h0, buf_sel});
    $display("test geometry done");
  endtask : t_geom

  task automatic t_toggle;
    wr(8'h10, 32'h7);
    wr(8'h14, 32'h1);
    wr(8'h08, 32'h84);
    pk(6'h10, 4'hB);
    rd("toggle set", 8'h08, 32'hA4);
    chk("irq on", 32'h1, {31'h0, irq});
    pk(6'h10, 4'hA);
    rd("toggle kept", 8'h08, 32'hA4);
    wr(8'h10, 32'h1);
    rd("status clear", 8'h10, 32'h0);
    chk("irq off", 32'h0, {31'h0, irq});
    wr(8'h08, 32'hA0);
    pk(6'h18, 4'hB);
    rd("no irq bit", 8'h10, 32'h0);
    $display("test toggle done");
  endtask : t_toggle

  task automatic t_stall;
    wr(8'h14, 32'h7);
    wr(8'h08, 32'h88);
    pk(6'h10, 4'hC);
    pk(6'h30, 4'hB);
    wr(8'h08, 32'h80);
    pk(6'h16, 4'hC);
    rd("auto stall", 8'h08, 32'h88);
    rd("stall flag", 8'h10, 32'h2);
    chk("stall irq", 32'h1, {31'h0, irq});
    wr(8'h10, 32'h2);
    $display("test stall done");
  endtask : t_stall

  task automatic t_iso;
    wr(8'h08, 32'hC0);
    pk(6'h10, 4'h1);
    chk("iso second", 32'h1, {31'h0, buf_sel.second});
    pk(6'h11, 4'h0);
    rd("overflow", 8'h08, 32'hE0);
    rd("iso status", 8'h10, 32'h5);
    wr(8'h10, 32'h7);
    wr(8'h08, 32'h00);
    pk(6'h10, 4'h0);
    rd("off status", 8'h10, 32'h0);
    wr(8'h08, 32'h90);
    chk("restart primary", 32'h0, {31'h0, buf_sel.second});
    $display("test iso and off done");
  endtask : t_iso

  // Main sequence; all inputs get a value at time zero.
  initial begin
    rst_n = 1'h0;
    cyc_i = 1'h0;
    stb_i = 1'h0;
    we_i = 1'h0;
    adr_i = 8'h00;
    sel_i = 4'h0;
    dat_i = 32'h0;
    send = 1'h0;
    pkt = 6'h00;
    repeat (5) @(posedge mclk);
    rst_n <= 1'h1;
    t_reset;
    t_geom;
    t_toggle;
    t_stall;
    t_iso;
    end_sim;
  end

  // Watchdog: the tests need well under a thousand cycles.
  initial begin
    repeat (5000) @(posedge mclk);
    bad_count++;
    end_sim;
  end
endmodule : tb

bind usb_oep_cfg usb_oep_assertions usb_oep_assertions_i (.mclk(mclk), .rst_n(rst_n),
  .cyc_i(cyc_i), .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .rx(rx), .handshake(handshake), .buf_sel(buf_sel),
  .stored(stored), .active(active), .iso_mode(iso_mode), .irq(irq));

/* testbench/usb_host_model.sv */
`timescale 1ns/1ns
// ==========================================================================
// Host model: sends one out data packet for each send request.
module usb_host_model (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic send,
  input wire logic [5:0] pkt,
  output usb_oep_pkg::rx_event_t rx
);
  // Between packets the qualifiers churn rather than hold, so a design that
  // reads them without the done pulse cannot pass by luck.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      rx <= '0;
    end else if (send) begin
      rx <= {1'h1, pkt};
    end else begin
      rx <= {1'h0, ~rx[5:0]};
    end
  end
endmodule : usb_host_model

/* testbench/usb_oep_assertions.sv */
`timescale 1ns/1ns
// ==========================================================================
// Port checker for the out endpoint configuration block.
module usb_oep_assertions (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [usb_oep_pkg::WB_AW-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input usb_oep_pkg::rx_event_t rx,
  input usb_oep_pkg::handshake_out_t handshake,
  input usb_oep_pkg::buf_sel_t buf_sel,
  input wire logic stored,
  input wire logic active,
  input wire logic iso_mode,
  input wire logic irq
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);

  // A configuration write shows while its acknowledge stands and the request is held.
  sequence cfg_wr;
    $rose(ack_o) && we_i && sel_i[0] && adr_i == usb_oep_pkg::ADDR_CONFIG;
  endsequence
  sequence pkt_in;
    rx.done;
  endsequence

  // Bus answer timing, then the rule relations.
  chk_ack_pulse: assert property (ack_o |=> !ack_o)
    else $error("acknowledge stood longer than one cycle");
  chk_ack_next: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
    else $error("acknowledge missing after a request");
  chk_active_bit: assert property (cfg_wr |-> active == dat_i[7])
    else $error("active does not follow the written enable");
  chk_iso_bit: assert property (cfg_wr |-> iso_mode == dat_i[6])
    else $error("iso mode does not follow the written bit");
  chk_off_quiet: assert property (pkt_in ##0 !active |=> !handshake.valid && !stored)
    else $error("disabled endpoint answered a packet");
  chk_iso_silent: assert property (pkt_in ##0 iso_mode |=> !handshake.valid)
    else $error("handshake given on an iso endpoint");
  chk_store_ack: assert property (stored && !iso_mode |->
    handshake.valid && handshake.code == usb_oep_pkg::HS_ACK)
    else $error("stored packet without an ack");
  chk_base_align: assert property (buf_sel.base[2:0] == 3'h0)
    else $error("buffer base not on an eight byte boundary");
  chk_size_units: assert property (buf_sel.size[2:0] == 3'h0)
    else $error("buffer size not in eight byte units");
  chk_start_primary: assert property ($rose(active) |-> !buf_sel.second)
    else $error("enable did not start on the primary buffer");

  cover property (pkt_in ##1 stored);
endmodule : usb_oep_assertions

/* verilog/usb_oep_buf_select.sv */
`timescale 1ns/1ns
module usb_oep_buf_select (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic enable,
  input wire logic two_buf,
  input wire logic advance,
  input wire logic [7:0] size_code,
  input wire logic [7:0] pri_code,
  input wire logic [7:0] sec_code,
  output usb_oep_pkg::buf_sel_t sel
);

  logic second_r;
  logic second_nxt;
  usb_oep_pkg::buf_sel_t sel_r;

  // ==========================================================================
  // Buffer alternation
  // ==========================================================================
  // A disabled endpoint parks on the primary buffer, so enabling restarts there.
  always_comb begin
    second_nxt = second_r;
    if (!enable) begin
      second_nxt = 1'b0;
    end else if (!two_buf) begin
      second_nxt = 1'b0;
    end else if (advance) begin
      second_nxt = ~second_r;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      second_r <= 1'b0;
    end else begin
      second_r <= second_nxt;
    end
  end

  // The address and size seen by the buffer manager come from one flop stage.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sel_r <= '0;
    end else begin
      sel_r.second <= second_nxt;
      sel_r.base <= second_nxt ? usb_oep_pkg::base_addr(sec_code)
                               : usb_oep_pkg::base_addr(pri_code);
      sel_r.size <= {size_code, {usb_oep_pkg::UNIT_BITS{1'b0}}};
    end
  end

  assign sel = sel_r;

endmodule : usb_oep_buf_select

/* verilog/usb_oep_cfg.sv */
`timescale 1ns/1ns
module usb_oep_cfg (
  input wire logic mclk,
  input wire logic rst_n,
  // Classic Wishbone slave.
  input wire logic cyc_i,
  input wire logic stb_i,
  input wire logic we_i,
  input wire logic [usb_oep_pkg::WB_AW-1:0] adr_i,
  input wire logic [3:0] sel_i,
  input wire logic [31:0] dat_i,
  output logic [31:0] dat_o,
  output logic ack_o,
  // Received packets from the serial engine, same clock.
  input usb_oep_pkg::rx_event_t rx,
  // Answer to the host and buffer placement for the next packet.
  output usb_oep_pkg::handshake_out_t handshake,
  output usb_oep_pkg::buf_sel_t buf_sel,
  output logic stored,
  output logic active,
  output logic iso_mode,
  output logic irq
);

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic [7:0] size_r;
  logic [7:0] pri_r;
  logic [7:0] sec_r;
  logic [7:0] cfg_r;
  logic [7:0] cfg_nxt;
  logic ack_r;
  logic [31:0] dat_r;
  usb_oep_pkg::handshake_out_t hs_r;
  usb_oep_pkg::handshake_out_t hs_nxt;
  logic stored_r;
  logic active_r;
  logic iso_r;
  logic take;
  logic wr_lane;
  logic wr_size;
  logic wr_pri;
  logic wr_sec;
  logic wr_cfg;
  logic wr_clr;
  logic wr_mask;
  logic [usb_oep_pkg::IRQ_W-1:0] irq_set;
  logic [usb_oep_pkg::IRQ_W-1:0] irq_status;
  logic [usb_oep_pkg::IRQ_W-1:0] irq_mask;
  logic on;
  logic iso;
  logic stall;
  logic expect1;
  logic advance;
  logic flip_toggle;
  logic set_stall;
  logic set_overflow;
  logic rx_irq;

  // ==========================================================================
  // Wishbone slave
  // ==========================================================================
  // A request is taken on the first edge it is seen; ack follows that edge
  // and drops in the next cycle, so every access takes exactly two cycles with
  // one wait state, and a request held past its ack is taken again once ack drops.
  assign take = cyc_i && stb_i && !ack_r;
  assign wr_lane = take && we_i && sel_i[0];
  assign wr_size = wr_lane && (adr_i == usb_oep_pkg::ADDR_BUF_SIZE);
  assign wr_pri = wr_lane && (adr_i == usb_oep_pkg::ADDR_PRI_BASE);
  assign wr_sec = wr_lane && (adr_i == usb_oep_pkg::ADDR_SEC_BASE);
  assign wr_cfg = wr_lane && (adr_i == usb_oep_pkg::ADDR_CONFIG);
  assign wr_clr = wr_lane && (adr_i == usb_oep_pkg::ADDR_IRQ_STAT);
  assign wr_mask = wr_lane && (adr_i == usb_oep_pkg::ADDR_IRQ_MASK);

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= take;
    end
  end

  // Read data is captured with the request; unmapped words read as zero.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dat_r <= '0;
    end else if (take) begin
      case (adr_i)
        usb_oep_pkg::ADDR_BUF_SIZE: dat_r <= {24'h000000, size_r};
        usb_oep_pkg::ADDR_PRI_BASE: dat_r <= {24'h000000, pri_r};
        usb_oep_pkg::ADDR_SEC_BASE: dat_r <= {24'h000000, sec_r};
        usb_oep_pkg::ADDR_CONFIG: dat_r <= {24'h000000, cfg_r};
        usb_oep_pkg::ADDR_IRQ_STAT: dat_r <= {{(32 - usb_oep_pkg::IRQ_W){1'b0}}, irq_status};
        usb_oep_pkg::ADDR_IRQ_MASK: dat_r <= {{(32 - usb_oep_pkg::IRQ_W){1'b0}}, irq_mask};
        default: dat_r <= '0;
      endcase
    end
  end

  // ==========================================================================
  // Plain software registers
  // ==========================================================================
  // Shared buffer size in eight-byte units.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      size_r <= usb_oep_pkg::BUF_SIZE_RESET;
    end else if (wr_size) begin
      size_r <= dat_i[7:0];
    end
  end

  // Primary base, address bits ten to three.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pri_r <= usb_oep_pkg::BASE_RESET;
    end else if (wr_pri) begin
      pri_r <= dat_i[7:0];
    end
  end

  // Secondary base, same layout as the primary one.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sec_r <= usb_oep_pkg::BASE_RESET;
    end else if (wr_sec) begin
      sec_r <= dat_i[7:0];
    end
  end

  // ==========================================================================
  // Packet decision
  // ==========================================================================
  assign on = cfg_r[usb_oep_pkg::CFG_ON];
  assign iso = cfg_r[usb_oep_pkg::CFG_ISO];
  assign stall = cfg_r[usb_oep_pkg::CFG_STALL];
  assign expect1 = cfg_r[usb_oep_pkg::CFG_TOGGLE];

  // Decides the handshake and side effects of one finished data packet.
  // Isochronous traffic never gets a handshake and bits 5..0 are then
  // overflow and bytes-per-sample, so toggle and stall are left alone.
  always_comb begin
    hs_nxt = '0;
    advance = 1'b0;
    flip_toggle = 1'b0;
    set_stall = 1'b0;
    set_overflow = 1'b0;
    if (rx.done && on) begin
      if (iso) begin
        if (rx.overflow) begin
          set_overflow = 1'b1;
        end else if (rx.crc_ok) begin
          advance = 1'b1;
        end
      end else if (stall && !rx.setup) begin
        hs_nxt.valid = 1'b1;
        hs_nxt.code = usb_oep_pkg::HS_STALL;
      end else if (rx.ctrl_write && rx.too_long && !rx.setup) begin
        hs_nxt.valid = 1'b1;
        hs_nxt.code = usb_oep_pkg::HS_STALL;
        set_stall = 1'b1;
      end else if (rx.crc_ok) begin
        hs_nxt.valid = 1'b1;
        hs_nxt.code = usb_oep_pkg::HS_ACK;
        if (rx.setup) begin
          advance = 1'b1;
        end else if (rx.data1 == expect1) begin
          advance = 1'b1;
          flip_toggle = 1'b1;
        end
      end
    end
  end

  // ==========================================================================
  // Configuration byte, written by software and updated by hardware
  // ==========================================================================
  // Hardware updates land on top of a same-cycle software write, so a stall
  // the hardware raises or a toggle it owes is never overwritten.
  always_comb begin
    cfg_nxt = wr_cfg ? dat_i[7:0] : cfg_r;
    if (flip_toggle) begin
      cfg_nxt[usb_oep_pkg::CFG_TOGGLE] = ~cfg_nxt[usb_oep_pkg::CFG_TOGGLE];
    end
    if (set_stall) begin
      cfg_nxt[usb_oep_pkg::CFG_STALL] = 1'b1;
    end
    if (set_overflow) begin
      cfg_nxt[usb_oep_pkg::CFG_OVERFLOW] = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg_r <= usb_oep_pkg::CONFIG_RESET;
    end else begin
      cfg_r <= cfg_nxt;
    end
  end

  // ==========================================================================
  // Handshake and status outputs
  // ==========================================================================
  // One-cycle pulses, one edge after the packet's done strobe.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      hs_r <= '0;
      stored_r <= 1'b0;
    end else begin
      hs_r <= hs_nxt;
      stored_r <= advance;
    end
  end

  // Level copies of the mode, so the engine sees flop outputs only.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      active_r <= 1'b0;
      iso_r <= 1'b0;
    end else begin
      active_r <= cfg_nxt[usb_oep_pkg::CFG_ON];
      iso_r <= cfg_nxt[usb_oep_pkg::CFG_ISO];
    end
  end

  // ==========================================================================
  // Buffer selection
  // ==========================================================================
  // Isochronous layout has no double-buffer bit, so it always ping-pongs.
  usb_oep_buf_select u_buf_select (
    .mclk(mclk),
    .rst_n(rst_n),
    .enable(cfg_nxt[usb_oep_pkg::CFG_ON]),
    .two_buf(cfg_nxt[usb_oep_pkg::CFG_TWO_BUF] || cfg_nxt[usb_oep_pkg::CFG_ISO]),
    .advance(advance),
    .size_code(wr_size ? dat_i[7:0] : size_r),
    .pri_code(wr_pri ? dat_i[7:0] : pri_r),
    .sec_code(wr_sec ? dat_i[7:0] : sec_r),
    .sel(buf_sel)
  );

  // ==========================================================================
  // Interrupts
  // ==========================================================================
  // Packet-received events count while the endpoint's interrupt enable bit 2 is on, and always on an isochronous endpoint;
  // the automatic stall is always reported because firmware must see it.
  assign rx_irq = advance && (iso || cfg_r[usb_oep_pkg::CFG_IRQ_ON]);

  always_comb begin
    irq_set = '0;
    irq_set[usb_oep_pkg::IRQ_RX_DONE] = rx_irq;
    irq_set[usb_oep_pkg::IRQ_AUTO_STALL] = set_stall;
    irq_set[usb_oep_pkg::IRQ_OVERFLOW] = set_overflow;
  end

  usb_oep_irq #(
    .W(usb_oep_pkg::IRQ_W)
  ) u_irq (
    .mclk(mclk),
    .rst_n(rst_n),
    .set(irq_set),
    .clr_wr(wr_clr),
    .mask_wr(wr_mask),
    .wr_data(dat_i[usb_oep_pkg::IRQ_W-1:0]),
    .status(irq_status),
    .mask(irq_mask),
    .irq(irq)
  );

  assign dat_o = dat_r;
  assign ack_o = ack_r;
  assign handshake = hs_r;
  assign stored = stored_r;
  assign active = active_r;
  assign iso_mode = iso_r;

endmodule : usb_oep_cfg

/* verilog/usb_oep_irq.sv */
`timescale 1ns/1ns
module usb_oep_irq #(
  parameter int unsigned W = 3
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic [W-1:0] set,
  input wire logic clr_wr,
  input wire logic mask_wr,
  input wire logic [W-1:0] wr_data,
  output logic [W-1:0] status,
  output logic [W-1:0] mask,
  output logic irq
);

  logic [W-1:0] status_r;
  logic [W-1:0] status_nxt;
  logic [W-1:0] mask_r;
  logic irq_r;

  // ==========================================================================
  // Sticky status, write one to clear
  // ==========================================================================
  // A set in the clearing cycle wins, so no event is lost to a racing clear.
  always_comb begin
    status_nxt = status_r;
    if (clr_wr) begin
      status_nxt = status_nxt & ~wr_data;
    end
    status_nxt = status_nxt | set;
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      status_r <= '0;
    end else begin
      status_r <= status_nxt;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mask_r <= '0;
    end else if (mask_wr) begin
      mask_r <= wr_data;
    end
  end

  // Level output, one cycle behind the status it reflects.
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(status_r & mask_r);
    end
  end

  assign status = status_r;
  assign mask = mask_r;
  assign irq = irq_r;

endmodule : usb_oep_irq

/* verilog/usb_oep_pkg.sv */
// Overview of operation
// - Both packet buffers take one shared size, programmed in eight-byte units.
// - Primary buffer base is eleven bits; the programmed byte gives bits ten to three.
// - Low three base address bits are always zero, so buffers sit on eight-byte boundaries.
// - Endpoint is active only while configuration bit 7 is one.
// - Configuration bit 6 selects isochronous traffic; software clears it otherwise.
// - Toggle bit 5 inverts after a good out data packet whose PID matches.
// - Configuration bit 4 at one uses both primary and secondary buffers.
// - With bit 4 at zero only the primary buffer receives packets, unless the endpoint is isochronous.
// - Configuration bits mean different things for isochronous and other endpoints.
// - While stall bit 3 is set, answer STALL, but always accept setup stages.
// - A control write delivering too much data sets stall and raises an interrupt.
// - The packet-received interrupt needs configuration bit 2 at one except on isochronous endpoints; stall and overflow events ignore it.
package usb_oep_pkg;

  // ==========================================================================
  // Register map, one aligned word per register, data in the low byte
  // ==========================================================================
  localparam int unsigned WB_AW = 8;
  localparam logic [7:0] ADDR_BUF_SIZE = 8'h00;
  localparam logic [7:0] ADDR_PRI_BASE = 8'h04;
  localparam logic [7:0] ADDR_CONFIG = 8'h08;
  localparam logic [7:0] ADDR_SEC_BASE = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_STAT = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h14;

  // Reset values of the software registers.
  localparam logic [7:0] BUF_SIZE_RESET = 8'h00;
  localparam logic [7:0] BASE_RESET = 8'h00;
  localparam logic [7:0] CONFIG_RESET = 8'h00;

  // ==========================================================================
  // Configuration byte fields
  // ==========================================================================
  localparam int unsigned CFG_ON = 7;
  localparam int unsigned CFG_ISO = 6;
  localparam int unsigned CFG_TOGGLE = 5;
  localparam int unsigned CFG_OVERFLOW = 5;
  localparam int unsigned CFG_TWO_BUF = 4;
  localparam int unsigned CFG_STALL = 3;
  localparam int unsigned CFG_IRQ_ON = 2;

  // ==========================================================================
  // Interrupt status and mask layout
  // ==========================================================================
  localparam int unsigned IRQ_W = 3;
  localparam int unsigned IRQ_RX_DONE = 0;
  localparam int unsigned IRQ_AUTO_STALL = 1;
  localparam int unsigned IRQ_OVERFLOW = 2;

  // ==========================================================================
  // Buffer geometry
  // ==========================================================================
  localparam int unsigned ADDR_W = 11;
  localparam int unsigned UNIT_BITS = 3;

  // One received data packet as reported by the serial engine, on mclk.
  typedef struct packed {
    logic done;
    logic setup;
    logic crc_ok;
    logic data1;
    logic ctrl_write;
    logic too_long;
    logic overflow;
  } rx_event_t;

  typedef enum logic [1:0] {
    HS_NONE,
    HS_ACK,
    HS_STALL
  } handshake_t;

  typedef struct packed {
    logic valid;
    handshake_t code;
  } handshake_out_t;

  typedef struct packed {
    logic [ADDR_W-1:0] base;
    logic [ADDR_W-1:0] size;
    logic second;
  } buf_sel_t;

  // Base byte to eleven-bit address with the low bits forced to zero.
  function automatic logic [ADDR_W-1:0] base_addr(input logic [7:0] code);
    base_addr = {code, {UNIT_BITS{1'b0}}};
  endfunction : base_addr

endpackage : usb_oep_pkg
